// *** motion_pkg.sv ***
// constants, register map and helpers for the motion detector
// assumes: one 250 MHz core clock, registers on 32-bit word slots
package motion_pkg;

  // ******************************************************
  // widths
  // ******************************************************
  localparam int SAMPLE_WIDTH = 12;
  localparam int THRESHOLD_WIDTH = 11;
  localparam int DURATION_WIDTH = 24;
  localparam int MAG_WIDTH = 16;
  localparam int SCALE_SHIFT = 4;
  localparam int AXIS_COUNT = 3;
  localparam int ADDR_WIDTH = 10;
  localparam int INDEX_LSB = 2;

  // ******************************************************
  // register indices (byte address is four times the index)
  // ******************************************************
  localparam logic [7:0] IDX_AXIS_SELECT = 8'h38;
  localparam logic [7:0] IDX_MOTION_THR_HIGH = 8'h39;
  localparam logic [7:0] IDX_MOTION_THR_LOW = 8'h3a;
  localparam logic [7:0] IDX_ACT_DUR_HIGH = 8'h3b;
  localparam logic [7:0] IDX_ACT_DUR_MID = 8'h3c;
  localparam logic [7:0] IDX_ACT_DUR_LOW = 8'h3d;
  localparam logic [7:0] IDX_STILL_THR_HIGH = 8'h3e;
  localparam logic [7:0] IDX_STILL_THR_LOW = 8'h3f;
  localparam logic [7:0] IDX_STILL_DUR_HIGH = 8'h40;
  localparam logic [7:0] IDX_STILL_DUR_MID = 8'h41;
  localparam logic [7:0] IDX_STILL_DUR_LOW = 8'h42;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h50;

  // ******************************************************
  // fields and reset values
  // ******************************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int THR_HIGH_BITS = 3;
  localparam int STATUS_ACT_BIT = 0;
  localparam int STATUS_STILL_BIT = 1;
  localparam int STATUS_ABOVE_LSB = 2;
  localparam int STATUS_BELOW_LSB = 5;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int TICK_US = 500;
  localparam int CORE_CLK_MHZ = 250;
  localparam int TICK_CYCLES = TICK_US * CORE_CLK_MHZ;

  typedef enum logic [2:0] {
    QUAL_WAIT = 3'b001,
    QUAL_COUNT = 3'b010,
    QUAL_FIRED = 3'b100
  } qual_state_type;

  // absolute value of a signed sample, times sixteen
  function automatic logic [MAG_WIDTH-1:0] magnitude_x16(
    input logic [SAMPLE_WIDTH-1:0] sample
  );
    logic [SAMPLE_WIDTH-1:0] mag;
    mag = sample[SAMPLE_WIDTH-1] ? (~sample + 12'h001) : sample;
    return {mag, 4'h0};
  endfunction : magnitude_x16

endpackage : motion_pkg

// *** qual_timer.sv ***
// duration qualifier: condition must hold a number of ticks
// assumes: tick is a one-cycle pulse, cond is valid with sample_valid
`timescale 1ns/1ps
module qual_timer
  import motion_pkg::*;
#(
  parameter int WIDTH = DURATION_WIDTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic sample_valid,
  input wire logic cond,
  input wire logic [WIDTH-1:0] duration,
  output logic event_pulse
);

  // ******************************************************
  // state
  // ******************************************************
  qual_state_type state;
  qual_state_type next_state;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_event_pulse;
  logic expired;

  always_comb begin
    next_state = state;
    next_count = count;
    next_event_pulse = 1'b0;
    // zero duration fires on the first qualifying sample
    expired = (duration == '0) || (count >= duration);
    case (state)
      QUAL_WAIT: begin
        if (sample_valid && cond) begin
          if (duration == '0) begin
            next_event_pulse = 1'b1;
            next_state = QUAL_FIRED;
          end else begin
            next_state = QUAL_COUNT;
            next_count = '0;
          end
        end
      end
      QUAL_COUNT: begin
        if (sample_valid && !cond) begin
          next_state = QUAL_WAIT;
          next_count = '0;
        end else if (sample_valid && expired) begin
          next_event_pulse = 1'b1;
          next_state = QUAL_FIRED;
        end else if (tick && count != '1) begin
          // one count per 500 us tick; saturates, never wraps
          next_count = count + 1'b1;
        end
      end
      QUAL_FIRED: begin
        // one event per episode; rearm only after the condition lapses
        if (sample_valid && !cond) begin
          next_state = QUAL_WAIT;
          next_count = '0;
        end
      end
      default: begin
        next_state = QUAL_WAIT;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= QUAL_WAIT;
      count <= '0;
      event_pulse <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      event_pulse <= next_event_pulse;
    end
  end

endmodule : qual_timer

// *** motion_detector.sv ***
// activity and stillness detection with an Avalon-MM register slave
// assumes: samples come from logic on core_clk, one per sample_valid
//
// Contract
// - activity duration is 24 bits over three bytes
// - nonzero activity duration rejects brief motion
// - activity after any enabled axis stays above
// - each duration count is 500 us
// - stillness after all enabled axes stay below
// - nonzero stillness duration needs unbroken stillness
// - stillness compares absolute sample to 11-bit threshold
// - sample is scaled by sixteen before comparing
// - thresholds are raw codes, no range rescaling
// - stillness threshold split high/low, upper bits reserved
// - activity uses same scaled compare, split threshold
// - three-bit axis select, zero disables all
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module motion_detector
  import motion_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] sample_x,
  input wire logic [SAMPLE_WIDTH-1:0] sample_y,
  input wire logic [SAMPLE_WIDTH-1:0] sample_z,
  output logic activity_event,
  output logic stillness_event,
  output logic activity_flag,
  output logic stillness_flag
);

  localparam int TICK_CW = $clog2(TICK_PERIOD + 1);
  localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_PERIOD - 1);

  // ******************************************************
  // register storage
  // ******************************************************
  logic [AXIS_COUNT-1:0] detect_axis_select;
  logic [AXIS_COUNT-1:0] next_detect_axis_select;
  logic [THRESHOLD_WIDTH-1:0] motion_threshold;
  logic [THRESHOLD_WIDTH-1:0] next_motion_threshold;
  logic [THRESHOLD_WIDTH-1:0] stillness_threshold;
  logic [THRESHOLD_WIDTH-1:0] next_stillness_threshold;
  logic [DURATION_WIDTH-1:0] activity_duration;
  logic [DURATION_WIDTH-1:0] next_activity_duration;
  logic [DURATION_WIDTH-1:0] stillness_duration;
  logic [DURATION_WIDTH-1:0] next_stillness_duration;
  logic next_activity_flag;
  logic next_stillness_flag;
  logic [AXIS_COUNT-1:0] axis_above;
  logic [AXIS_COUNT-1:0] next_axis_above;
  logic [AXIS_COUNT-1:0] axis_below;
  logic [AXIS_COUNT-1:0] next_axis_below;

  // ******************************************************
  // bus handshake
  // ******************************************************
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [7:0] reg_index;
  logic bus_request;
  logic write_commit;
  logic [7:0] wbyte;

  assign reg_index = avs_address[INDEX_LSB +: 8];
  assign bus_request = avs_read || avs_write;
  // a write lands only at the edge where waitrequest is seen low
  assign write_commit = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // ******************************************************
  // comparison path
  // ******************************************************
  logic [MAG_WIDTH-1:0] mag [AXIS_COUNT];
  logic [AXIS_COUNT-1:0] above_now;
  logic [AXIS_COUNT-1:0] below_now;
  logic motion_cond;
  logic stillness_cond;

  always_comb begin
    mag[0] = magnitude_x16(sample_x);
    mag[1] = magnitude_x16(sample_y);
    mag[2] = magnitude_x16(sample_z);
    for (int i = 0; i < AXIS_COUNT; i++) begin
      // threshold in raw codes; no range-dependent scaling here
      above_now[i] = mag[i] > MAG_WIDTH'(motion_threshold);
      below_now[i] = mag[i] < MAG_WIDTH'(stillness_threshold);
    end
    // no axis selected: neither condition can ever hold
    motion_cond = |(above_now & detect_axis_select);
    stillness_cond = (detect_axis_select != '0) &&
      ((below_now | ~detect_axis_select) == '1);
  end

  // ******************************************************
  // 500 us timebase
  // ******************************************************
  logic [TICK_CW-1:0] tick_count;
  logic [TICK_CW-1:0] next_tick_count;
  logic tick;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_tick_count = tick_count + 1'b1;
    if (tick_count == TICK_LAST) begin
      next_tick_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      tick <= next_tick;
    end
  end

  // ******************************************************
  // qualification timers
  // ******************************************************
  qual_timer #(
    .WIDTH(DURATION_WIDTH)
  ) activity_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick),
    .sample_valid(sample_valid),
    .cond(motion_cond),
    .duration(activity_duration),
    .event_pulse(activity_event)
  );

  qual_timer #(
    .WIDTH(DURATION_WIDTH)
  ) stillness_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick),
    .sample_valid(sample_valid),
    .cond(stillness_cond),
    .duration(stillness_duration),
    .event_pulse(stillness_event)
  );

  // ******************************************************
  // register writes and status flags
  // ******************************************************
  always_comb begin
    next_detect_axis_select = detect_axis_select;
    next_motion_threshold = motion_threshold;
    next_stillness_threshold = stillness_threshold;
    next_activity_duration = activity_duration;
    next_stillness_duration = stillness_duration;
    next_activity_flag = activity_flag;
    next_stillness_flag = stillness_flag;
    next_axis_above = axis_above;
    next_axis_below = axis_below;
    if (sample_valid) begin
      next_axis_above = above_now;
      next_axis_below = below_now;
    end
    if (write_commit) begin
      case (reg_index)
        IDX_AXIS_SELECT: begin
          next_detect_axis_select = wbyte[AXIS_COUNT-1:0];
        end
        IDX_MOTION_THR_HIGH: begin
          next_motion_threshold[10:8] = wbyte[THR_HIGH_BITS-1:0];
        end
        IDX_MOTION_THR_LOW: begin
          next_motion_threshold[7:0] = wbyte;
        end
        IDX_ACT_DUR_HIGH: begin
          next_activity_duration[23:16] = wbyte;
        end
        IDX_ACT_DUR_MID: begin
          next_activity_duration[15:8] = wbyte;
        end
        IDX_ACT_DUR_LOW: begin
          next_activity_duration[7:0] = wbyte;
        end
        IDX_STILL_THR_HIGH: begin
          // upper five bits are reserved and not stored
          next_stillness_threshold[10:8] = wbyte[THR_HIGH_BITS-1:0];
        end
        IDX_STILL_THR_LOW: begin
          next_stillness_threshold[7:0] = wbyte;
        end
        IDX_STILL_DUR_HIGH: begin
          next_stillness_duration[23:16] = wbyte;
        end
        IDX_STILL_DUR_MID: begin
          next_stillness_duration[15:8] = wbyte;
        end
        IDX_STILL_DUR_LOW: begin
          next_stillness_duration[7:0] = wbyte;
        end
        IDX_EVENT_STATUS: begin
          // write one to clear
          if (wbyte[STATUS_ACT_BIT]) begin
            next_activity_flag = 1'b0;
          end
          if (wbyte[STATUS_STILL_BIT]) begin
            next_stillness_flag = 1'b0;
          end
        end
        default: begin
          next_activity_flag = activity_flag;
        end
      endcase
    end
    // set after clear so a same-cycle event is never lost
    if (activity_event) begin
      next_activity_flag = 1'b1;
    end
    if (stillness_event) begin
      next_stillness_flag = 1'b1;
    end
  end

  // ******************************************************
  // read mux and waitrequest
  // ******************************************************
  always_comb begin
    next_readdata = avs_readdata;
    // one wait state: answer is prepared while waitrequest is high
    next_waitrequest = !(bus_request && avs_waitrequest);
    if (avs_read && avs_waitrequest) begin
      next_readdata = 32'h0000_0000;
      case (reg_index)
        IDX_AXIS_SELECT: begin
          next_readdata[AXIS_COUNT-1:0] = detect_axis_select;
        end
        IDX_MOTION_THR_HIGH: begin
          next_readdata[THR_HIGH_BITS-1:0] = motion_threshold[10:8];
        end
        IDX_MOTION_THR_LOW: begin
          next_readdata[7:0] = motion_threshold[7:0];
        end
        IDX_ACT_DUR_HIGH: begin
          next_readdata[7:0] = activity_duration[23:16];
        end
        IDX_ACT_DUR_MID: begin
          next_readdata[7:0] = activity_duration[15:8];
        end
        IDX_ACT_DUR_LOW: begin
          next_readdata[7:0] = activity_duration[7:0];
        end
        IDX_STILL_THR_HIGH: begin
          // reserved bits read back as zero
          next_readdata[THR_HIGH_BITS-1:0] = stillness_threshold[10:8];
        end
        IDX_STILL_THR_LOW: begin
          next_readdata[7:0] = stillness_threshold[7:0];
        end
        IDX_STILL_DUR_HIGH: begin
          next_readdata[7:0] = stillness_duration[23:16];
        end
        IDX_STILL_DUR_MID: begin
          next_readdata[7:0] = stillness_duration[15:8];
        end
        IDX_STILL_DUR_LOW: begin
          next_readdata[7:0] = stillness_duration[7:0];
        end
        IDX_EVENT_STATUS: begin
          next_readdata[STATUS_ACT_BIT] = activity_flag;
          next_readdata[STATUS_STILL_BIT] = stillness_flag;
          next_readdata[STATUS_ABOVE_LSB +: AXIS_COUNT] = axis_above;
          next_readdata[STATUS_BELOW_LSB +: AXIS_COUNT] = axis_below;
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      detect_axis_select <= BYTE_RESET[AXIS_COUNT-1:0];
      motion_threshold <= {BYTE_RESET[2:0], BYTE_RESET};
      stillness_threshold <= {BYTE_RESET[2:0], BYTE_RESET};
      activity_duration <= {BYTE_RESET, BYTE_RESET, BYTE_RESET};
      stillness_duration <= {BYTE_RESET, BYTE_RESET, BYTE_RESET};
      activity_flag <= 1'b0;
      stillness_flag <= 1'b0;
      axis_above <= '0;
      axis_below <= '0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      detect_axis_select <= next_detect_axis_select;
      motion_threshold <= next_motion_threshold;
      stillness_threshold <= next_stillness_threshold;
      activity_duration <= next_activity_duration;
      stillness_duration <= next_stillness_duration;
      activity_flag <= next_activity_flag;
      stillness_flag <= next_stillness_flag;
      axis_above <= next_axis_above;
      axis_below <= next_axis_below;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

endmodule : motion_detector

// *** motion_detector_asserts.sv ***
// checker: port timing of the motion detector
// assumes: bound into motion_detector, one clock domain
`timescale 1ns/1ps
module motion_detector_asserts
  import motion_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic activity_event,
  input wire logic stillness_event,
  input wire logic activity_flag,
  input wire logic stillness_flag
);
  // ******************************************
  // helpers and sequences
  // ******************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic wr_status;
  // a status write lands only at the edge after the wait state, where waitrequest is seen low
  assign wr_status = avs_write && !avs_waitrequest && avs_byteenable[0]
    && (avs_address[9:2] == IDX_EVENT_STATUS);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // ******************************************
  // assertions
  // ******************************************
  a_bus_answer: assert property (s_req |=> s_done)
    else $error("bus request not answered after one wait state");
  a_data_upper: assert property (!avs_waitrequest |->
    avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_thr_reserved: assert property (avs_read && !avs_waitrequest &&
    avs_address[9:2] == IDX_STILL_THR_HIGH |-> avs_readdata[7:3] == 5'h00)
    else $error("reserved threshold bits not zero");
  a_act_pulse: assert property (activity_event |=> !activity_event)
    else $error("activity event longer than one cycle");
  a_act_sample: assert property (activity_event |->
    $past(sample_valid))
    else $error("activity event without a sample");
  a_still_sample: assert property (stillness_event |->
    $past(sample_valid))
    else $error("stillness event without a sample");
  a_act_flag: assert property (activity_event |=> activity_flag)
    else $error("activity flag not set after event");
  a_still_flag: assert property (stillness_event |=> stillness_flag)
    else $error("stillness flag not set after event");
  a_act_sticky: assert property (activity_flag &&
    !(wr_status && avs_writedata[0]) |=> activity_flag)
    else $error("activity flag dropped without clear");
  a_still_sticky: assert property (stillness_flag &&
    !(wr_status && avs_writedata[1]) |=> stillness_flag)
    else $error("stillness flag dropped without clear");
  a_act_clear: assert property (wr_status && avs_writedata[0] &&
    !activity_event |=> !activity_flag)
    else $error("activity flag not cleared by write");
  a_still_clear: assert property (wr_status && avs_writedata[1] &&
    !stillness_event |=> !stillness_flag)
    else $error("stillness flag not cleared by write");
endmodule : motion_detector_asserts

bind motion_detector motion_detector_asserts motion_detector_asserts_inst (
  .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_valid(sample_valid), .activity_event(activity_event),
  .stillness_event(stillness_event), .activity_flag(activity_flag),
  .stillness_flag(stillness_flag));

// *** tb.sv ***
// testbench: register access and motion/stillness qualification
// assumes: motion_detector with a short tick period of 8 cycles
`timescale 1ns/1ps
module tb;
  import motion_pkg::*;
  localparam int TP = 8;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_WIDTH-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic sample_valid, activity_event, stillness_event;
  logic activity_flag, stillness_flag;
  logic [SAMPLE_WIDTH-1:0] sample_x, sample_y, sample_z;
  int error_cnt, compares, cyc, act_cnt, still_cnt, act_cyc, base, t0;
  motion_detector #(.TICK_PERIOD(TP)) motion_detector_inst (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z),
    .activity_event(activity_event), .stillness_event(stillness_event),
    .activity_flag(activity_flag), .stillness_flag(stillness_flag));
  // ******************************************
  // clock, monitor and tasks
  // ******************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // the ceiling sits well above the ~2500 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (activity_event === 1'b1) begin
      act_cnt++;
      act_cyc = cyc;
    end
    if (stillness_event === 1'b1) still_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD time=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // the extra edge at the end keeps two requests from sharing a step
  task automatic bus(input logic wr, input logic [7:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk({24'h000000, q}, {24'h000000, exp});
  endtask : rdc
  task automatic smp(input logic [11:0] x, input logic [11:0] y,
    input logic [11:0] z);
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
  endtask : smp
  // ******************************************
  // tests
  // ******************************************
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    sample_valid = 1'b0;
    sample_x = 12'h000;
    sample_y = 12'h000;
    sample_z = 12'h000;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 8'h38; i <= 8'h42; i++) rdc(i[7:0], 8'h00);
    wr(IDX_ACT_DUR_MID, 8'hff);
    rdc(IDX_ACT_DUR_MID, 8'hff);
    wr(IDX_ACT_DUR_LOW, 8'ha5);
    rdc(IDX_ACT_DUR_LOW, 8'ha5);
    wr(IDX_STILL_THR_HIGH, 8'hff);
    rdc(IDX_STILL_THR_HIGH, 8'h07);
    wr(IDX_STILL_THR_LOW, 8'hff);
    wr(8'h20, 8'h5a);
    rdc(8'h20, 8'h00);
    avs_byteenable <= 4'h0;
    wr(IDX_STILL_THR_LOW, 8'h00);
    avs_byteenable <= 4'hf;
    rdc(IDX_STILL_THR_LOW, 8'hff);
    wr(IDX_ACT_DUR_MID, 8'h00);
    wr(IDX_ACT_DUR_LOW, 8'h00);
    wr(IDX_STILL_THR_HIGH, 8'h00);
    wr(IDX_STILL_THR_LOW, 8'h20);
    // activity, zero duration, x only, threshold 256 codes
    wr(IDX_AXIS_SELECT, 8'h01);
    wr(IDX_MOTION_THR_HIGH, 8'h01);
    wr(IDX_MOTION_THR_LOW, 8'h00);
    smp(12'd16, 12'd0, 12'd0);
    smp(12'd17, 12'd0, 12'd0);
    smp(12'd17, 12'd0, 12'd0);
    smp(12'd0, 12'd0, 12'd0);
    smp(12'hfef, 12'd0, 12'd0);
    smp(12'd0, 12'd100, 12'd0);
    smp(12'h800, 12'd0, 12'd0);
    smp(12'd0, 12'd0, 12'd0);
    chk(act_cnt, 3);
    rdc(IDX_EVENT_STATUS, 8'he3);
    wr(IDX_EVENT_STATUS, 8'h03);
    chk({stillness_flag, activity_flag}, 32'h0000_0000);
    rdc(IDX_EVENT_STATUS, 8'he0);
    // activity over 256 counts; a lapse must restart the count
    wr(IDX_ACT_DUR_MID, 8'h01);
    base = act_cnt;
    repeat (100) smp(12'd17, 12'd0, 12'd0);
    smp(12'd0, 12'd0, 12'd0);
    chk(act_cnt - base, 0);
    t0 = cyc;
    for (int i = 0; i < 1200 && act_cnt == base; i++) begin
      smp(12'd17, 12'd0, 12'd0);
    end
    chk(act_cnt - base, 1);
    chk((act_cyc - t0 >= 255 * TP) && (act_cyc - t0 <= 257 * TP + 4),
      1);
    wr(IDX_ACT_DUR_MID, 8'h00);
    // stillness, all axes, threshold 32 codes
    wr(IDX_AXIS_SELECT, 8'h07);
    smp(12'd2, 12'd0, 12'd0);
    base = still_cnt;
    smp(12'd1, 12'd1, 12'hfff);
    smp(12'd2, 12'd0, 12'd0);
    chk(still_cnt - base, 1);
    wr(IDX_STILL_DUR_LOW, 8'h03);
    base = still_cnt;
    repeat (7) smp(12'd1, 12'd1, 12'd1);
    smp(12'd0, 12'd2, 12'd0);
    repeat (7) smp(12'd1, 12'd1, 12'd1);
    chk(still_cnt - base, 0);
    repeat (20) smp(12'd1, 12'd1, 12'd1);
    chk(still_cnt - base, 1);
    // no axis selected: neither detector may fire
    wr(IDX_AXIS_SELECT, 8'h00);
    wr(IDX_STILL_DUR_LOW, 8'h00);
    base = act_cnt + still_cnt;
    smp(12'd0, 12'd0, 12'd0);
    smp(12'h7ff, 12'h7ff, 12'h7ff);
    smp(12'd0, 12'd0, 12'd0);
    chk(act_cnt + still_cnt - base, 0);
    // reset in mid-run: flags and settings must return to zero
    chk({stillness_flag, activity_flag}, 32'h0000_0003);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk({stillness_flag, activity_flag}, 32'h0000_0000);
    rdc(IDX_EVENT_STATUS, 8'h00);
    rdc(IDX_STILL_THR_LOW, 8'h00);
    rdc(IDX_MOTION_THR_HIGH, 8'h00);
    summarize();
  end
endmodule : tb
